// File: core/agi_top.sv
// What this block does
// - Config bit 0 turns result bytes into port
// - High byte selects address, low byte writes
// - Gain registers never read back
// - Gain twelve bits: coarse byte, fine nibble
// - Additive select bit 0 sets gain-add
//
// Holds the indirect gain access window on the result registers.
// Assumes single-cycle register strobes from the processor bus,
// and a conversion engine that supplies results with a strobe.
`include "agi_cfg.svh"
module agi_top
   import agi_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   // Register strobes
   input  wire logic              cfg_wr_in,
   input  wire agi_pkg::agi_byte_t cfg_wdata_in,
   input  wire logic              res_high_wr_in,
   input  wire logic              res_low_wr_in,
   input  wire agi_pkg::agi_byte_t res_wdata_in,
   // Conversion results
   input  wire logic              conv_done_in,
   input  wire logic [11:0]       conv_result_in,
   // Register read views
   output agi_pkg::agi_byte_t     adc_config_out,
   output agi_pkg::agi_byte_t     adc_result_high_out,
   output agi_pkg::agi_byte_t     adc_result_low_out,
   // Gain outputs
   output logic [11:0]            gain_out,
   output logic                   gain_add_control_out,
   output logic                   gain_window_enable_out
);
   import agi_pkg::*;

   // Configuration group
   agi_byte_t   cfg_q;
   agi_byte_t   cfg_d;
   // Result group
   agi_byte_t   hi_q;
   agi_byte_t   hi_d;
   agi_byte_t   lo_q;
   agi_byte_t   lo_d;
   // Access port group
   agi_byte_t   idx_q;
   agi_byte_t   idx_d;
   agi_sel_t    sel_q;
   agi_sel_t    sel_d;
   logic        wen_q;
   logic        wen_d;
   agi_byte_t   wdat_q;
   agi_byte_t   wdat_d;
   // Gain copy group
   logic [11:0] gain_w;
   logic        add_w;
   logic [11:0] gain_q;
   logic [11:0] gain_d;
   logic        add_q;
   logic        add_d;
   logic        win;

   agi_wr_if wr_bus ();

   function automatic agi_sel_t agi_decode(input agi_byte_t idx);
      case (idx)
         `AGI_IDX_COARSE: agi_decode = AGI_SEL_COARSE;
         `AGI_IDX_FINE:   agi_decode = AGI_SEL_OTHER;
         `AGI_IDX_ADDSEL: agi_decode = AGI_SEL_OTHER;
         default:         agi_decode = AGI_SEL_NONE;
      endcase
   endfunction

   assign win = cfg_q[`AGI_CFG_GAIN_WINDOW_ENABLE_BIT];

   // Configuration register; the window follows one cycle after a write
   always_comb
   begin
      cfg_d = cfg_q;
      if (cfg_wr_in)
      begin
         cfg_d = cfg_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cfg_q <= `AGI_RST_BYTE;
      end
      else
      begin
         cfg_q <= cfg_d;
      end
   end

   // Result registers; a closed-window write beats a same-cycle result
   always_comb
   begin
      hi_d = hi_q;
      lo_d = lo_q;
      // Conversions during the window still update results; software
      // is expected not to start one then
      if (conv_done_in)
      begin
         hi_d = {4'h0, conv_result_in[11:8]};
         lo_d = conv_result_in[7:0];
      end
      if (!win && res_high_wr_in)
      begin
         hi_d = res_wdata_in;
      end
      if (!win && res_low_wr_in)
      begin
         lo_d = res_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         hi_q <= `AGI_RST_BYTE;
         lo_q <= `AGI_RST_BYTE;
      end
      else
      begin
         hi_q <= hi_d;
         lo_q <= lo_d;
      end
   end

   // Access port: the high byte latches the index, the low byte sends data
   always_comb
   begin
      idx_d  = idx_q;
      sel_d  = sel_q;
      wen_d  = 1'b0;
      wdat_d = wdat_q;
      if (win && res_high_wr_in)
      begin
         idx_d = res_wdata_in;
         sel_d = agi_decode(res_wdata_in);
      end
      if (win && res_low_wr_in)
      begin
         // Unknown addresses are dropped rather than aliased
         case (sel_q)
            AGI_SEL_COARSE: wen_d = 1'b1;
            AGI_SEL_OTHER:  wen_d = 1'b1;
            AGI_SEL_NONE:   wen_d = 1'b0;
            default:        wen_d = 1'b0;
         endcase
         wdat_d = res_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         idx_q  <= `AGI_RST_BYTE;
         sel_q  <= AGI_SEL_NONE;
         wen_q  <= 1'b0;
         wdat_q <= `AGI_RST_BYTE;
      end
      else
      begin
         idx_q  <= idx_d;
         sel_q  <= sel_d;
         wen_q  <= wen_d;
         wdat_q <= wdat_d;
      end
   end

   assign wr_bus.wr_en   = wen_q;
   assign wr_bus.wr_idx  = idx_q;
   assign wr_bus.wr_data = wdat_q;

   agi_gain_store u_store
   (
      .core_clk_in          (core_clk_in),
      .rst_n_in             (rst_n_in),
      .wr                   (wr_bus),
      .gain_out             (gain_w),
      .gain_add_control_out (add_w)
   );

   // Registered copy keeps top outputs straight from flip-flops
   always_comb
   begin
      gain_d = gain_w;
      add_d  = add_w;
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         gain_q <= `AGI_RST_GAIN;
         add_q  <= 1'b0;
      end
      else
      begin
         gain_q <= gain_d;
         add_q  <= add_d;
      end
   end

   assign adc_config_out         = cfg_q;
   // Reads show result bytes only; gain contents never leak
   assign adc_result_high_out    = hi_q;
   assign adc_result_low_out     = lo_q;
   assign gain_out               = gain_q;
   assign gain_add_control_out   = add_q;
   assign gain_window_enable_out = cfg_q[`AGI_CFG_GAIN_WINDOW_ENABLE_BIT];
endmodule

// File: core/agi_cfg.svh
// Constants for the indirect gain access block.
// Assumes inclusion by the main module and the gain store only.
`ifndef AGI_CFG_SVH
`define AGI_CFG_SVH
`define AGI_IDX_COARSE     8'h04
`define AGI_IDX_FINE       8'h07
`define AGI_IDX_ADDSEL     8'h08
`define AGI_CFG_GAIN_WINDOW_ENABLE_BIT 0
`define AGI_ADD_BIT        0
`define AGI_RST_BYTE       8'h00
`define AGI_RST_GAIN       12'h000
`endif

// File: core/agi_pkg.sv
// Types shared by the gain access block.
// Assumes no surroundings beyond the config header.
package agi_pkg;
   typedef enum logic [2:0]
   {
      AGI_SEL_NONE   = 3'b001,
      AGI_SEL_COARSE = 3'b010,
      AGI_SEL_OTHER  = 3'b100
   } agi_sel_t;
   typedef logic [7:0] agi_byte_t;
endpackage

// File: core/agi_wr_if.sv
// Internal write bundle between the access port and the gain store.
// Assumes one clock domain.
interface agi_wr_if;
   logic       wr_en;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   modport src (output wr_en, output wr_idx, output wr_data);
   modport dst (input wr_en, input wr_idx, input wr_data);
endinterface

// File: core/agi_gain_store.sv
// Write-only gain register store.
// Assumes writes arrive only while the gain window is open.
`include "agi_cfg.svh"
module agi_gain_store
   import agi_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   // Write bundle
   agi_wr_if.dst            wr,
   // Stored gain
   output logic [11:0]      gain_out,
   output logic             gain_add_control_out
);
   logic [7:0] coarse_q, coarse_d;
   logic [3:0] fine_q, fine_d;
   logic       add_q, add_d;

   always_comb
   begin
      coarse_d = coarse_q;
      fine_d   = fine_q;
      add_d    = add_q;
      if (wr.wr_en)
      begin
         case (wr.wr_idx)
            `AGI_IDX_COARSE: coarse_d = wr.wr_data;
            `AGI_IDX_FINE:   fine_d   = wr.wr_data[7:4];
            `AGI_IDX_ADDSEL: add_d    = wr.wr_data[`AGI_ADD_BIT];
            default:         coarse_d = coarse_q;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         coarse_q <= `AGI_RST_BYTE;
         fine_q   <= 4'h0;
         add_q    <= 1'b0;
      end
      else
      begin
         coarse_q <= coarse_d;
         fine_q   <= fine_d;
         add_q    <= add_d;
      end
   end

   assign gain_out             = {coarse_q, fine_q};
   assign gain_add_control_out = add_q;
endmodule

// File: tb/agi_top_assertions.sv
// Port checker for the indirect gain access block.
// Assumes agi_top ports; bound below.
module agi_chk
   import agi_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        cfg_wr_in,
   input  wire agi_byte_t   cfg_wdata_in,
   input  wire logic        res_high_wr_in,
   input  wire logic        res_low_wr_in,
   input  wire agi_byte_t   res_wdata_in,
   input  wire logic        conv_done_in,
   input  wire logic [11:0] conv_result_in,
   input  wire agi_byte_t   adc_result_high_out,
   input  wire agi_byte_t   adc_result_low_out,
   input  wire logic [11:0] gain_out,
   input  wire logic        gain_add_control_out,
   input  wire logic        gain_window_enable_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   agi_byte_t idx_q;
   logic      gw;
   // Mirror of the latched index, only written while the window is open
   always_ff @(posedge core_clk_in or negedge rst_n_in)
      if (!rst_n_in)
         idx_q <= 8'h00;
      else if (res_high_wr_in && gain_window_enable_out)
         idx_q <= res_wdata_in;
   assign gw = res_low_wr_in && gain_window_enable_out;
   win_follow_a: assert property (cfg_wr_in |=>
      gain_window_enable_out == $past(cfg_wdata_in[0])) else $error("win");
   coarse_wr_a: assert property (gw && idx_q == 8'h04 |->
      ##3 gain_out[11:4] == $past(res_wdata_in, 3)) else $error("coarse");
   fine_wr_a: assert property (gw && idx_q == 8'h07 |->
      ##3 gain_out[3:0] == $past(res_wdata_in[7:4], 3)) else $error("fine");
   add_wr_a: assert property (gw && idx_q == 8'h08 |-> ##3
      gain_add_control_out == $past(res_wdata_in[0], 3)) else $error("add");
   no_readback_a: assert property (gw && !conv_done_in |=>
      $stable(adc_result_low_out) && $stable(adc_result_high_out))
      else $error("readback");
   gain_cause_a: assert property ($changed(gain_out) |->
      $past(gw, 3)) else $error("stray gain");
   add_cause_a: assert property ($changed(gain_add_control_out) |->
      $past(gw, 3)) else $error("stray add");
   conv_hi_a: assert property (conv_done_in && !res_high_wr_in
      |=> adc_result_high_out == {4'h0, $past(conv_result_in[11:8])})
      else $error("conv hi");
   result_wr_a: assert property (res_high_wr_in && !gain_window_enable_out
      |=> adc_result_high_out == $past(res_wdata_in))
      else $error("result wr");
   conv_res_a: assert property (conv_done_in && !res_low_wr_in
      |=> adc_result_low_out == $past(conv_result_in[7:0]))
      else $error("conv");
endmodule
bind agi_top agi_chk chk_u (.core_clk_in, .rst_n_in, .cfg_wr_in,
   .cfg_wdata_in, .res_high_wr_in, .res_low_wr_in, .res_wdata_in,
   .conv_done_in, .conv_result_in, .adc_result_high_out,
   .adc_result_low_out, .gain_out, .gain_add_control_out,
   .gain_window_enable_out);

// File: tb/tb.sv
// Self-checking bench for the indirect gain access block.
// Assumes the design and checker files are compiled first.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import agi_pkg::*;
   logic        clk = 0;
   logic        rst_n = 0;
   logic [2:0]  wr = 0;
   agi_byte_t   wd = 0;
   logic        cd = 0;
   logic [11:0] cr = 0;
   agi_byte_t   cfg_o, hi_o, lo_o;
   logic [11:0] g_o, g_e;
   logic        a_o, w_o;
   logic [15:0] lf = 16'h0037;
   int          error_cnt = 0;
   int          checks = 0;
   int          cyc = 0;
   always #2 clk = ~clk;
   agi_top dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .cfg_wr_in(wr[0]),
      .cfg_wdata_in(wd), .res_high_wr_in(wr[1]), .res_low_wr_in(wr[2]),
      .res_wdata_in(wd), .conv_done_in(cd), .conv_result_in(cr),
      .adc_config_out(cfg_o), .adc_result_high_out(hi_o),
      .adc_result_low_out(lo_o), .gain_out(g_o),
      .gain_add_control_out(a_o), .gain_window_enable_out(w_o));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Coarse byte on top, fine register's upper nibble below it
   function automatic logic [11:0] exp_gain(input agi_byte_t c,
                                            input agi_byte_t f);
      return {c, f[7:4]};
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [11:0] e,
                      input logic [11:0] g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // One idle cycle between strobes keeps each strobe a clean pulse
   task automatic w1(input int k, input agi_byte_t d);
      @(negedge clk);
      wr[k] = 1'b1;
      wd = d;
      @(negedge clk);
      wr = 3'h0;
   endtask
   task automatic pg(input agi_byte_t c, input agi_byte_t f,
                     input agi_byte_t a);
      w1(0, 8'h01);
      cmp("window", 12'h001, {11'h000, w_o});
      cmp("cfg", 12'h001, {4'h0, cfg_o});
      w1(1, 8'h04);
      w1(2, c);
      w1(1, 8'h07);
      w1(2, f);
      w1(1, 8'h08);
      w1(2, a);
      w1(0, 8'h00);
      g_e = exp_gain(c, f);
      cmp("gain", g_e, g_o);
      cmp("add", {11'h000, a[0]}, {11'h000, a_o});
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         tally_and_finish;
      end
   end
   initial
   begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      cmp("gain_rst", 12'h000, g_o);
      pg(8'h6c, 8'ha0, 8'h01);
      cmp("example", 12'h6ca, g_o);
      for (int i = 0; i < 8; i++)
      begin
         lf = nx(lf);
         pg(lf[7:0], lf[15:8], lf[11:4]);
         w1(1, lf[7:0]);
         w1(2, lf[15:8]);
         cmp("res_hi", {4'h0, lf[7:0]}, {4'h0, hi_o});
         cmp("res_lo", {4'h0, lf[15:8]}, {4'h0, lo_o});
         w1(0, 8'h01);
         w1(1, 8'h05);
         w1(2, ~lf[7:0]);
         w1(0, 8'h00);
         cmp("gain_kept", g_e, g_o);
         cmp("no_leak_hi", {4'h0, lf[7:0]}, {4'h0, hi_o});
         cmp("no_leak_lo", {4'h0, lf[15:8]}, {4'h0, lo_o});
         @(negedge clk);
         // Conversions only start with the window closed
         cd = 1'b1;
         cr = lf[11:0];
         @(negedge clk);
         cd = 1'b0;
         cmp("conv_lo", {4'h0, lf[7:0]}, {4'h0, lo_o});
         cmp("conv_hi", {8'h00, lf[11:8]}, {4'h0, hi_o});
      end
      // Mid-run reset with the window open must close it again
      w1(0, 8'h01);
      rst_n = 1'b0;
      @(negedge clk);
      cmp("rst_cfg", 12'h000, {4'h0, cfg_o});
      cmp("rst_gain", 12'h000, g_o);
      cmp("rst_add", 12'h000, {11'h000, a_o});
      rst_n = 1'b1;
      pg(8'h12, 8'h3f, 8'h00);
      // Corner: a closed-window write beats a same-cycle result
      @(negedge clk);
      cd = 1'b1;
      cr = 12'h3c5;
      wr[1] = 1'b1;
      wd = 8'h5a;
      @(negedge clk);
      cd = 1'b0;
      wr = 3'h0;
      cmp("wr_wins", 12'h05a, {4'h0, hi_o});
      cmp("conv_lo2", 12'h0c5, {4'h0, lo_o});
      tally_and_finish;
   end
endmodule
